// ===== design/lposc_tick.sv
module lposc_tick #(
   parameter int DIV = wdt_pkg::LPOSC_DIV
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic run_i,
   // Tick
   output logic tick_o
);

   logic [15:0] div_reg;

   // Stands in for the low-power oscillator edge as a clock enable
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         div_reg <= 16'h0000;
         tick_o <= 1'b0;
      end else if (div_reg == 16'(DIV - 1)) begin
         div_reg <= 16'h0000;
         tick_o <= 1'b1;
      end else begin
         div_reg <= div_reg + 16'h0001;
         tick_o <= 1'b0;
      end
   end

endmodule : lposc_tick

// ===== design/watchdog_timer_control.sv
module watchdog_timer_control #(
   parameter int LPOSC_DIV = wdt_pkg::LPOSC_DIV
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [15:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Configuration word and power state
   input wire logic [31:0] device_config_word_one_i,
   input wire logic sleep_i,
   input wire logic idle_i,
   // Watchdog actions
   output logic device_reset_o,
   output logic wake_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration synchroniser and capture

   logic [31:0] cfg_meta_reg;
   logic [31:0] cfg_sync_reg;
   logic [1:0] cfg_wait_reg;
   logic cfg_valid_reg;
   logic [wdt_pkg::PS_W-1:0] run_postscale_value_reg;
   logic forced_enable_fuse_reg;

   always_ff @(posedge clk_i) begin
      cfg_meta_reg <= device_config_word_one_i;
      cfg_sync_reg <= cfg_meta_reg;
   end

   // Wait for the synchroniser to fill before latching the fuses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_wait_reg <= 2'h0;
         cfg_valid_reg <= 1'b0;
      end else if (!cfg_valid_reg) begin
         cfg_wait_reg <= cfg_wait_reg + 2'h1;
         cfg_valid_reg <= (cfg_wait_reg == 2'h2);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_postscale_value_reg <= 5'h00;
         forced_enable_fuse_reg <= 1'b0;
      end else if (!cfg_valid_reg && cfg_wait_reg == 2'h2) begin
         run_postscale_value_reg <=
            cfg_sync_reg[wdt_pkg::PS_CFG_LSB +: wdt_pkg::PS_W];
         forced_enable_fuse_reg <= cfg_sync_reg[wdt_pkg::FUSE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone decode

   logic req;
   logic wr_fire;
   logic hit_ctrl;
   logic hit_clr;
   logic hit_set;
   logic hit_inv;
   logic hit_status;
   logic hit_mask;
   logic hit_count;
   logic key_write;

   assign req = cyc_i && stb_i;
   // Write acts at the edge where the master sees ack
   assign wr_fire = req && ack_o && we_i;
   assign hit_ctrl = (adr_i == wdt_pkg::ADDR_CONTROL);
   assign hit_clr = (adr_i == wdt_pkg::ADDR_CONTROL_CLR);
   assign hit_set = (adr_i == wdt_pkg::ADDR_CONTROL_SET);
   assign hit_inv = (adr_i == wdt_pkg::ADDR_CONTROL_INV);
   assign hit_status = (adr_i == wdt_pkg::ADDR_STATUS);
   assign hit_mask = (adr_i == wdt_pkg::ADDR_MASK);
   assign hit_count = (adr_i == wdt_pkg::ADDR_COUNT);

   // Key must arrive in one write covering both upper byte lanes
   assign key_write = wr_fire && hit_ctrl && (sel_i[3:2] == 2'b11)
      && (dat_i[wdt_pkg::KEY_LSB +: 16] == wdt_pkg::CLEAR_KEY);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req && !ack_o;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control bits

   logic on_reg;
   logic window_mode_enable_reg;
   logic on_next;
   logic win_next;

   always_comb begin
      on_next = on_reg;
      win_next = window_mode_enable_reg;
      if (wr_fire) begin
         if (hit_ctrl && sel_i[1]) begin
            on_next = dat_i[wdt_pkg::ON_BIT];
         end
         if (hit_ctrl && sel_i[0]) begin
            win_next = dat_i[wdt_pkg::WIN_BIT];
         end
         if (hit_clr && sel_i[1] && dat_i[wdt_pkg::ON_BIT]) begin
            on_next = 1'b0;
         end
         if (hit_clr && sel_i[0] && dat_i[wdt_pkg::WIN_BIT]) begin
            win_next = 1'b0;
         end
         if (hit_set && sel_i[1] && dat_i[wdt_pkg::ON_BIT]) begin
            on_next = 1'b1;
         end
         if (hit_set && sel_i[0] && dat_i[wdt_pkg::WIN_BIT]) begin
            win_next = 1'b1;
         end
         if (hit_inv && sel_i[1] && dat_i[wdt_pkg::ON_BIT]) begin
            on_next = !on_reg;
         end
         if (hit_inv && sel_i[0] && dat_i[wdt_pkg::WIN_BIT]) begin
            win_next = !window_mode_enable_reg;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         on_reg <= 1'b0;
         window_mode_enable_reg <= 1'b0;
      end else begin
         on_reg <= on_next;
         window_mode_enable_reg <= win_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Time base and counter

   logic wdt_run;
   logic lp_tick;
   logic [wdt_pkg::CNT_W-1:0] count_reg;
   logic [wdt_pkg::CNT_W-1:0] period_last;
   logic [wdt_pkg::CNT_W-1:0] window_start;
   logic [wdt_pkg::PS_W-1:0] ps_eff;
   logic expire;
   logic early_key;

   // Hold off until the fuses are known
   assign wdt_run = cfg_valid_reg && (forced_enable_fuse_reg || on_reg);

   lposc_tick #(
      .DIV(LPOSC_DIV)
   ) u_lposc_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(wdt_run),
      .tick_o(lp_tick)
   );

   // Settings past the longest period are clamped to it
   assign ps_eff = (run_postscale_value_reg > wdt_pkg::PS_MAX) ?
      wdt_pkg::PS_MAX : run_postscale_value_reg;
   assign period_last = (wdt_pkg::CNT_W'(1) << ps_eff) - wdt_pkg::CNT_W'(1);
   assign window_start = period_last - (period_last >> wdt_pkg::WIN_SHIFT);
   assign expire = wdt_run && lp_tick && (count_reg == period_last);
   assign early_key = key_write && wdt_run && window_mode_enable_reg
      && (count_reg < window_start);

   always_ff @(posedge clk_i) begin
      if (rst_i || !wdt_run) begin
         count_reg <= '0;
      end else if (key_write || expire) begin
         count_reg <= '0;
      end else if (lp_tick) begin
         count_reg <= count_reg + wdt_pkg::CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset and wake actions

   logic low_power;

   assign low_power = sleep_i || idle_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         device_reset_o <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         device_reset_o <= (expire && !low_power) || early_key;
         wake_o <= expire && low_power;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event status and interrupt

   logic [wdt_pkg::ST_W-1:0] status_reg;
   logic [wdt_pkg::ST_W-1:0] mask_reg;
   logic [wdt_pkg::ST_W-1:0] events;
   logic [wdt_pkg::ST_W-1:0] w1c;

   assign events[wdt_pkg::ST_TIMEOUT] = expire && !low_power;
   assign events[wdt_pkg::ST_WAKE] = expire && low_power;
   assign events[wdt_pkg::ST_WINFAULT] = early_key;
   assign w1c = (wr_fire && hit_status && sel_i[0]) ?
      dat_i[wdt_pkg::ST_W-1:0] : '0;

   // New event beats a same-cycle clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_reg <= wdt_pkg::ST_RESET;
      end else begin
         status_reg <= (status_reg & ~w1c) | events;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_reg <= wdt_pkg::ST_RESET;
      end else if (wr_fire && hit_mask && sel_i[0]) begin
         mask_reg <= dat_i[wdt_pkg::ST_W-1:0];
      end
   end

   assign irq_o = |(status_reg & mask_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   logic [31:0] ctrl_view;

   always_comb begin
      ctrl_view = 32'h0000_0000;
      ctrl_view[wdt_pkg::ON_BIT] = on_reg;
      ctrl_view[wdt_pkg::DIV_LSB +: wdt_pkg::PS_W] = run_postscale_value_reg;
      ctrl_view[wdt_pkg::WIN_BIT] = window_mode_enable_reg;
   end

   // Aliases read back the control value; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req && !ack_o) begin
         if (hit_ctrl || hit_clr || hit_set || hit_inv) begin
            dat_o <= ctrl_view;
         end else if (hit_status) begin
            dat_o <= {29'h0, status_reg};
         end else if (hit_mask) begin
            dat_o <= {29'h0, mask_reg};
         end else if (hit_count) begin
            dat_o <= {11'h000, count_reg};
         end else begin
            dat_o <= 32'h0000_0000;
         end
      end
   end

endmodule : watchdog_timer_control

// ===== design/wdt_pkg.sv
//
// Summary of operation
// - Count only on low-power oscillator ticks
// - Uncleared time-out resets the device
// - Postscaler selects the time-out length
// - Time-out in Sleep or Idle wakes device
// - Only key 0x5743, 16-bit write, clears count
// - Key field bits 31-16 write-only, reads zero
// - Bit 15 enables module, resets to zero
// - Forced-enable fuse overrides the enable bit
// - Bits 12-8 show run postscale from configuration
// - Bit 0 selects windowed mode, resets zero
// - Bits 7-1 and 14-13 read zero
// - Clear, set, invert aliases at 0x4, 0x8, 0xC
package wdt_pkg;

   // Register byte addresses
   localparam logic [15:0] ADDR_CONTROL = 16'hF600;
   localparam logic [15:0] ADDR_CONTROL_CLR = 16'hF604;
   localparam logic [15:0] ADDR_CONTROL_SET = 16'hF608;
   localparam logic [15:0] ADDR_CONTROL_INV = 16'hF60C;
   localparam logic [15:0] ADDR_STATUS = 16'hF610;
   localparam logic [15:0] ADDR_MASK = 16'hF614;
   localparam logic [15:0] ADDR_COUNT = 16'hF618;

   // Control register fields
   localparam int KEY_LSB = 16;
   localparam int ON_BIT = 15;
   localparam int DIV_LSB = 8;
   localparam int WIN_BIT = 0;
   localparam logic [15:0] CLEAR_KEY = 16'h5743;

   // Configuration word fields
   localparam int FUSE_BIT = 23;
   localparam int PS_CFG_LSB = 0;
   localparam int PS_W = 5;
   localparam logic [4:0] PS_MAX = 5'h14;

   // Status and mask bits
   localparam int ST_W = 3;
   localparam int ST_TIMEOUT = 0;
   localparam int ST_WAKE = 1;
   localparam int ST_WINFAULT = 2;
   localparam logic [ST_W-1:0] ST_RESET = 3'h0;

   // Low-power oscillator tick rate
   localparam longint CLK_HZ = 125000000;
   localparam longint LPOSC_HZ = 32000;
   localparam int LPOSC_DIV = int'(CLK_HZ / LPOSC_HZ);

   // Counter width covers the longest postscale (2^20 ticks)
   localparam int CNT_W = 21;

   // Window opens for the last quarter of the period
   localparam int WIN_SHIFT = 2;

endpackage : wdt_pkg

// ===== dv/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // Short tick divider keeps the periods to a few dozen cycles
   localparam int DIV = 2;
   localparam logic [4:0] PS = 5'h4;
   localparam int PERIOD = 16 * DIV;
   localparam logic [31:0] BASE = {19'h0, PS, 8'h0};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [15:0] adr_i = 16'h0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] cfg = {27'h0, PS};
   logic sleep_i = 1'b0;
   logic idle_i = 1'b0;
   logic [31:0] dat_o;
   logic ack_o;
   logic device_reset_o;
   logic wake_o;
   logic irq_o;
   logic [31:0] rd;
   int fail_count = 0;
   int samples_checked = 0;
   int cyc_cnt = 0;
   int resets = 0;
   int wakes = 0;
   int last_t = 0;
   int prev_t = 0;
   int r0;
   always #4 clk_i = ~clk_i;
   watchdog_timer_control #(.LPOSC_DIV(DIV)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .device_config_word_one_i(cfg),
      .sleep_i(sleep_i), .idle_i(idle_i), .device_reset_o(device_reset_o),
      .wake_o(wake_o), .irq_o(irq_o));
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (device_reset_o === 1'b1) begin
         resets++;
         prev_t = last_t;
         last_t = cyc_cnt;
      end
      if (wake_o === 1'b1) wakes++;
      if (cyc_cnt == 20000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("unexpected %s: expected %h, seen %h", n, exp, seen);
         fail_count++;
      end
   endtask : chk
   // Classic single cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [15:0] a, input logic [3:0] s,
      input logic [31:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
   endtask : wb
   task automatic wait_reset_count(input int n);
      for (int i = 0; i < 400 && resets < n; i++) @(posedge clk_i);
   endtask : wait_reset_count
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [15:0] ad [4] = '{wdt_pkg::ADDR_CONTROL, wdt_pkg::ADDR_CONTROL_CLR,
         wdt_pkg::ADDR_CONTROL_SET, wdt_pkg::ADDR_CONTROL_INV};
      logic [31:0] wd [4] = '{32'hFFFFFFFF, 32'h8001, 32'h1, 32'h8001};
      logic [31:0] ex [4] = '{32'h8001, 32'h0, 32'h1, 32'h8000};
      wb(1'b0, wdt_pkg::ADDR_CONTROL, 4'hF, 32'h0);
      chk("control reset", rd, BASE);
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, ad[i], 4'h3, wd[i]);
         wb(1'b0, wdt_pkg::ADDR_CONTROL, 4'hF, 32'h0);
         chk("control alias", rd, BASE | ex[i]);
      end
      wb(1'b1, wdt_pkg::ADDR_CONTROL_CLR, 4'h3, 32'h8000);
      wb(1'b0, wdt_pkg::ADDR_COUNT, 4'hF, 32'h0);
      chk("count disabled", rd, 32'h0);
      wb(1'b1, 16'hF620, 4'hF, 32'hFFFFFFFF);
      wb(1'b0, 16'hF620, 4'hF, 32'h0);
      chk("unmapped", rd, 32'h0);
   endtask : t_regs
   task automatic t_timeout();
      wb(1'b1, wdt_pkg::ADDR_CONTROL, 4'h3, 32'h8000);
      wait_reset_count(resets + 3);
      chk("period", last_t - prev_t, PERIOD);
      wb(1'b1, wdt_pkg::ADDR_MASK, 4'hF, 32'h1);
      @(posedge clk_i);
      chk("irq raised", irq_o, 1'b1);
      wb(1'b0, wdt_pkg::ADDR_MASK, 4'hF, 32'h0);
      chk("mask readback", rd, 32'h1);
      wb(1'b1, wdt_pkg::ADDR_CONTROL_CLR, 4'h3, 32'h8000);
      wb(1'b1, wdt_pkg::ADDR_STATUS, 4'hF, 32'h7);
      @(posedge clk_i);
      chk("irq cleared", irq_o, 1'b0);
      wb(1'b0, wdt_pkg::ADDR_STATUS, 4'hF, 32'h0);
      chk("status cleared", rd, 32'h0);
   endtask : t_timeout
   task automatic t_key(input logic [15:0] key, input logic [3:0] s, input logic hit);
      r0 = resets;
      wb(1'b1, wdt_pkg::ADDR_CONTROL, 4'h3, 32'h8000);
      repeat (6) begin
         repeat (PERIOD / 2 - 4) @(posedge clk_i);
         wb(1'b1, wdt_pkg::ADDR_CONTROL, s, {key, 16'h0});
      end
      chk("timeout seen", resets != r0, hit);
      wb(1'b1, wdt_pkg::ADDR_CONTROL_CLR, 4'h3, 32'h8000);
   endtask : t_key
   // Sleep and Idle each get a run of their own
   task automatic t_wake(input logic s, input logic i);
      int w0;
      r0 = resets;
      w0 = wakes;
      sleep_i <= s;
      idle_i <= i;
      wb(1'b1, wdt_pkg::ADDR_CONTROL, 4'h3, 32'h8000);
      repeat (PERIOD + 8) @(posedge clk_i);
      wb(1'b1, wdt_pkg::ADDR_CONTROL_CLR, 4'h3, 32'h8000);
      sleep_i <= 1'b0;
      idle_i <= 1'b0;
      chk("wake", wakes != w0, 1'b1);
      chk("no reset asleep", resets, r0);
   endtask : t_wake
   task automatic t_window();
      r0 = resets;
      wb(1'b1, wdt_pkg::ADDR_CONTROL, 4'h3, 32'h8001);
      wb(1'b1, wdt_pkg::ADDR_CONTROL, 4'hC, {wdt_pkg::CLEAR_KEY, 16'h0});
      repeat (3) @(posedge clk_i);
      chk("early key", resets, r0 + 1);
      wb(1'b0, wdt_pkg::ADDR_STATUS, 4'hF, 32'h0);
      chk("window fault", rd & 32'h4, 32'h4);
      // Key near three quarters of the period lands inside the open window
      repeat (PERIOD / 2 + 2) @(posedge clk_i);
      wb(1'b1, wdt_pkg::ADDR_CONTROL, 4'hC, {wdt_pkg::CLEAR_KEY, 16'h0});
      repeat (3) @(posedge clk_i);
      chk("late key", resets, r0 + 1);
      wb(1'b1, wdt_pkg::ADDR_CONTROL_CLR, 4'h3, 32'h8001);
   endtask : t_window
   // Fuse is captured only after reset, so a second reset is needed
   task automatic t_fuse();
      @(posedge clk_i);
      rst_i <= 1'b1;
      cfg[wdt_pkg::FUSE_BIT] <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      r0 = resets;
      wait_reset_count(r0 + 1);
      chk("forced run", resets, r0 + 1);
   endtask : t_fuse
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      t_regs();
      t_timeout();
      t_key(wdt_pkg::CLEAR_KEY, 4'hC, 1'b0);
      t_key(16'h5742, 4'hC, 1'b1);
      t_key(wdt_pkg::CLEAR_KEY, 4'h4, 1'b1);
      t_wake(1'b1, 1'b0);
      t_wake(1'b0, 1'b1);
      t_window();
      t_fuse();
      end_sim();
   end
endmodule : testbench

bind watchdog_timer_control wdt_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
   .sleep_i(sleep_i), .idle_i(idle_i), .device_reset_o(device_reset_o), .wake_o(wake_o));

// ===== dv/wdt_monitor.sv
module wdt_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [15:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // Power state and actions
   input wire logic sleep_i,
   input wire logic idle_i,
   input wire logic device_reset_o,
   input wire logic wake_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   // Read answer of the control word, address held by the master
   sequence s_ctl_read;
      ack_o && !$past(we_i) && $past(adr_i) == wdt_pkg::ADDR_CONTROL;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_ack_latency: assert property (s_req |=> ack_o)
      else $error("ack missing one cycle after request");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_key_reads_zero: assert property (s_ctl_read |-> dat_o[31:16] == 16'h0)
      else $error("key field read not zero");
   a_spare_zero: assert property (s_ctl_read |-> !dat_o[14:13] && !dat_o[7:1])
      else $error("unimplemented bits read not zero");
   a_unmapped_zero: assert property (ack_o && !$past(we_i) && $past(adr_i) == 16'hF620
      |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_reset_pulse: assert property (device_reset_o |=> !device_reset_o)
      else $error("device reset longer than one cycle");
   a_wake_pulse: assert property (wake_o |=> !wake_o)
      else $error("wake longer than one cycle");
   a_wake_cause: assert property (wake_o |-> $past(sleep_i || idle_i))
      else $error("wake outside low power");
   a_quiet_release: assert property ($fell(rst_i) |-> !ack_o && !device_reset_o && !wake_o)
      else $error("outputs active after reset");
endmodule : wdt_monitor
